//--- verilog/sar_ctrl_pkg.sv
// Shared constants and carrier types for the converter start and serial readout logic
package sar_ctrl_pkg;
	// Result word
	localparam int RESULT_W = 12;
	localparam logic [11:0] RESULT_RESET = 12'h000;
	localparam int SIGN_BIT = 11;

	// Reference clock
	localparam int REF_PERIOD_NS = 100;

	// Conversion timing, figures in ns
	localparam int CONVERT_START_N_NS = 14000;
	localparam int DONE_TO_BUSY_NS = 1100;
	localparam int FIRST_CLK_NS = 1400;
	localparam int BIT_PERIOD_NS = 1100;
	localparam int CLK_HIGH_NS = 400;
	localparam int DATA_LEAD_NS = 300;

	// Derived cycle counts: least times round up
	localparam int CONVERT_START_N_CYC = (CONVERT_START_N_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
	localparam int DONE_TO_BUSY_CYC = (DONE_TO_BUSY_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
	localparam int BUSY_CYC = CONVERT_START_N_CYC + DONE_TO_BUSY_CYC;
	localparam int LOAD_CYC = BUSY_CYC - 1;
	localparam int FIRST_CLK_CYC = (FIRST_CLK_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
	localparam int BIT_CYC = (BIT_PERIOD_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
	localparam int CLK_HIGH_CYC = (CLK_HIGH_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
	localparam int DATA_LEAD_CYC = (DATA_LEAD_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
	// Output flops lag the phase counter by one cycle
	localparam int TX_START_CYC = FIRST_CLK_CYC - DATA_LEAD_CYC - 1;

	// Counter widths
	localparam int CYC_W = 8;
	localparam int PHASE_W = 4;
	localparam int BIT_W = 4;

	// Conversion sequencer states
	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_CONVERT = 3'h2,
		ST_SETTLE = 3'h4
	} convert_start_n_state_t;

	// Pin inputs that are synchronised together
	typedef struct packed {
		logic convert_start_n;
		logic cs_n;
		logic clock_source_select;
		logic bit_clk_level;
	} pin_in_t;
	localparam int PIN_IN_W = 4;
	// All four pins reset high, the idle level of start and select, so no false start edge follows reset
	localparam logic [3:0] PIN_IN_RESET = 4'hF;
endpackage

//--- verilog/sync2.sv
// Two flip-flop level synchroniser
`timescale 1ns/10ps
module sync2 #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clk, // Destination clock
	input wire logic nrst, // Async reset, active low
	input wire logic en, // Clock enable
	input wire logic [W-1:0] d, // Asynchronous input
	output logic [W-1:0] q // Synchronised output
);
	logic [W-1:0] meta_r;

	// First stage feeds only the second stage
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			meta_r <= RST_VAL;
			q <= RST_VAL;
		end else if (en) begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule // sync2

//--- verilog/link_shifter.sv
// External bit clock domain: shifts the held result out MSB first
`timescale 1ns/10ps
module link_shifter #(
	parameter int W = sar_ctrl_pkg::RESULT_W
) (
	input wire logic serial_bit_clock, // Host bit clock
	input wire logic nrst, // Async reset, active low
	input wire logic clear, // Load strobe from reference domain, active high
	input wire logic cs_n, // Device select pin, active low
	input wire logic [W-1:0] word, // Held result, static while clock runs
	output logic data // Serial data in external mode
);
	localparam int CNT_W = $clog2(W + 1);
	logic cs_n_s;
	logic [CNT_W-1:0] cnt_r;
	logic [W-1:0] shifted;

	// Select gates the host clock after two edges of it
	sync2 #(.W(1), .RST_VAL(1'b1)) u_cs_sync (
		.clk(serial_bit_clock),
		.nrst(nrst),
		.en(1'b1),
		.d(cs_n),
		.q(cs_n_s)
	);

	// Bits past the word width shift in as zero
	always_comb begin
		shifted = word << cnt_r;
	end

	// The clear only falls while the host holds the clock low, so its release is safe
	always_ff @(posedge serial_bit_clock or posedge clear) begin
		if (clear) begin
			cnt_r <= '0;
			data <= 1'b0;
		end else if (!cs_n_s) begin
			data <= shifted[W-1];
			if (cnt_r != CNT_W'(W))
				cnt_r <= cnt_r + 1'b1;
		end
	end
endmodule // link_shifter

//--- verilog/sar_readout.sv
// Conversion sequencer and serial result readout for the 12-bit sampling converter
// Summary of operation
// - Idle start falling edge holds and converts
// - Start input ignored during conversion
// - Start works whatever device select shows
// - Result coded as 12-bit two's complement
// - New result visible only after conversion ends
// - Internal mode sends previous result during conversion
// - Idle internal mode: data and clock low
// - Twelve bits MSB first, stable both edges
// - Busy low across whole internal transmission
// - External mode reads after, during, or both
// - Host rising edge starts MSB-first shifting
// - Clock high at load keeps old result
// - Beyond twelve clocks data goes low
// - Previous result readable during next conversion
// - Busy low during conversion, released by select
// - Select high disables outputs, gates clock
// - Internal transmission proceeds with select high
`timescale 1ns/10ps
module sar_readout #(
	parameter int W = sar_ctrl_pkg::RESULT_W
) (
	input wire logic ref_clk, // Converter clock, 10 MHz
	input wire logic nrst, // Async reset, active low
	input wire logic clk_en, // Freezes reference-domain state when low
	input wire logic convert_start_n, // Start pin, falling edge starts
	input wire logic cs_n, // Device select pin, active low
	input wire logic clock_source_select, // Pin: high selects host bit clock
	input wire logic serial_bit_clock, // Host bit clock, second domain
	input wire logic [W-1:0] sar_code, // Straight binary code from the SAR core
	output logic hold_o, // Sample-and-hold in hold, active high
	output logic busy_n_o, // Busy, active low
	output logic busy_oe_n, // Busy output enable, active low
	output logic data_o, // Serial data
	output logic data_oe_n, // Data output enable, active low
	output logic bit_clk_o, // Internal bit clock out
	output logic bit_clk_oe_n // Bit clock output enable, active low
);
	localparam logic [sar_ctrl_pkg::CYC_W-1:0] CONVERT_START_N_END =
		sar_ctrl_pkg::CYC_W'(sar_ctrl_pkg::CONVERT_START_N_CYC);
	localparam logic [sar_ctrl_pkg::CYC_W-1:0] LOAD_AT =
		sar_ctrl_pkg::CYC_W'(sar_ctrl_pkg::LOAD_CYC);
	localparam logic [sar_ctrl_pkg::CYC_W-1:0] BUSY_END =
		sar_ctrl_pkg::CYC_W'(sar_ctrl_pkg::BUSY_CYC);
	localparam logic [sar_ctrl_pkg::CYC_W-1:0] TX_AT =
		sar_ctrl_pkg::CYC_W'(sar_ctrl_pkg::TX_START_CYC);
	localparam logic [sar_ctrl_pkg::PHASE_W-1:0] PHASE_LAST =
		sar_ctrl_pkg::PHASE_W'(sar_ctrl_pkg::BIT_CYC - 1);
	localparam logic [sar_ctrl_pkg::PHASE_W-1:0] HI_FIRST =
		sar_ctrl_pkg::PHASE_W'(sar_ctrl_pkg::DATA_LEAD_CYC);
	localparam logic [sar_ctrl_pkg::PHASE_W-1:0] HI_LAST =
		sar_ctrl_pkg::PHASE_W'(sar_ctrl_pkg::DATA_LEAD_CYC + sar_ctrl_pkg::CLK_HIGH_CYC - 1);
	localparam logic [sar_ctrl_pkg::BIT_W-1:0] BIT_LAST = sar_ctrl_pkg::BIT_W'(W - 1);

	sar_ctrl_pkg::pin_in_t pins_raw;
	sar_ctrl_pkg::pin_in_t pins_s;
	sar_ctrl_pkg::convert_start_n_state_t state_r;
	sar_ctrl_pkg::convert_start_n_state_t state_nxt;
	logic [sar_ctrl_pkg::CYC_W-1:0] cyc_r;
	logic start_prev_r;
	logic start_fall;
	logic [W-1:0] work_r;
	logic [W-1:0] result_sr_r;
	logic load_blocked;
	logic load_now;
	logic clr_link_r;
	logic tx_active_r;
	logic [sar_ctrl_pkg::PHASE_W-1:0] phase_r;
	logic [sar_ctrl_pkg::BIT_W-1:0] bit_r;
	logic [W-1:0] tx_shift;
	logic int_data_r;
	logic link_data;
	logic mode_ext;

	// All pins pass two flops before any logic looks at them
	assign pins_raw.convert_start_n = convert_start_n;
	assign pins_raw.cs_n = cs_n;
	assign pins_raw.clock_source_select = clock_source_select;
	assign pins_raw.bit_clk_level = serial_bit_clock;

	sync2 #(.W(sar_ctrl_pkg::PIN_IN_W), .RST_VAL(sar_ctrl_pkg::PIN_IN_RESET)) u_pin_sync (
		.clk(ref_clk),
		.nrst(nrst),
		.en(clk_en),
		.d(pins_raw),
		.q(pins_s)
	);

	assign mode_ext = pins_s.clock_source_select;

	// Start edge detect on the synchronised level; select plays no part
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst)
			start_prev_r <= 1'b1;
		else if (clk_en)
			start_prev_r <= pins_s.convert_start_n;
	end

	assign start_fall = start_prev_r & ~pins_s.convert_start_n;

	// Sequencer next state: an edge outside idle is simply dropped
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			sar_ctrl_pkg::ST_IDLE: begin
				if (start_fall)
					state_nxt = sar_ctrl_pkg::ST_CONVERT;
			end
			sar_ctrl_pkg::ST_CONVERT: begin
				if (cyc_r == CONVERT_START_N_END)
					state_nxt = sar_ctrl_pkg::ST_SETTLE;
			end
			sar_ctrl_pkg::ST_SETTLE: begin
				if (cyc_r == BUSY_END)
					state_nxt = sar_ctrl_pkg::ST_IDLE;
			end
			default: state_nxt = sar_ctrl_pkg::ST_IDLE;
		endcase
	end

	// State register
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst)
			state_r <= sar_ctrl_pkg::ST_IDLE;
		else if (clk_en)
			state_r <= state_nxt;
	end

	// Cycle count from the accepted start edge
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst)
			cyc_r <= '0;
		else if (clk_en) begin
			if (state_r == sar_ctrl_pkg::ST_IDLE)
				cyc_r <= '0;
			else
				cyc_r <= cyc_r + 1'b1;
		end
	end

	// Hold lasts from the start edge until the decisions are made
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst)
			hold_o <= 1'b0;
		else if (clk_en) begin
			if (state_r == sar_ctrl_pkg::ST_IDLE && start_fall)
				hold_o <= 1'b1;
			else if (state_r == sar_ctrl_pkg::ST_CONVERT && cyc_r == CONVERT_START_N_END)
				hold_o <= 1'b0;
		end
	end

	// Busy low from start until the settle window ends
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst)
			busy_n_o <= 1'b1;
		else if (clk_en) begin
			if (state_r == sar_ctrl_pkg::ST_IDLE && start_fall)
				busy_n_o <= 1'b0;
			else if (state_r == sar_ctrl_pkg::ST_SETTLE && cyc_r == BUSY_END)
				busy_n_o <= 1'b1;
		end
	end

	// Working register: flipping the MSB turns straight binary into two's complement
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst)
			work_r <= sar_ctrl_pkg::RESULT_RESET;
		else if (clk_en && state_r == sar_ctrl_pkg::ST_CONVERT && cyc_r == CONVERT_START_N_END)
			work_r <= {~sar_code[sar_ctrl_pkg::SIGN_BIT], sar_code[W-2:0]};
	end

	// A host clock still high at load time would corrupt a read in flight
	assign load_blocked = mode_ext & pins_s.bit_clk_level & ~pins_s.cs_n;
	assign load_now = state_r == sar_ctrl_pkg::ST_SETTLE && cyc_r == LOAD_AT && !load_blocked;

	// Shift register keeps the previous result until just before busy rises
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst)
			result_sr_r <= sar_ctrl_pkg::RESULT_RESET;
		else if (clk_en && load_now)
			result_sr_r <= work_r;
	end

	// Clears the host-domain bit count; held during reset so the shifter starts clean
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst)
			clr_link_r <= 1'b1;
		else if (clk_en)
			clr_link_r <= load_now;
	end

	// Internal transmission runs inside each conversion, even with select high
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			tx_active_r <= 1'b0;
			phase_r <= '0;
			bit_r <= '0;
		end else if (clk_en) begin
			if (!tx_active_r) begin
				phase_r <= '0;
				bit_r <= '0;
				if (state_r == sar_ctrl_pkg::ST_CONVERT && cyc_r == TX_AT && !mode_ext)
					tx_active_r <= 1'b1;
			end else if (phase_r == PHASE_LAST) begin
				phase_r <= '0;
				if (bit_r == BIT_LAST)
					tx_active_r <= 1'b0;
				else
					bit_r <= bit_r + 1'b1;
			end else
				phase_r <= phase_r + 1'b1;
		end
	end

	// Current bit taken from the previous result, MSB first
	always_comb begin
		tx_shift = result_sr_r << bit_r;
	end

	// Data changes mid low phase, so it stands across both clock edges
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			int_data_r <= 1'b0;
			bit_clk_o <= 1'b0;
		end else if (clk_en) begin
			int_data_r <= tx_active_r & tx_shift[W-1];
			bit_clk_o <= tx_active_r && phase_r >= HI_FIRST && phase_r <= HI_LAST;
		end
	end

	// Host-clocked shifter for external mode
	link_shifter #(.W(W)) u_link (
		.serial_bit_clock(serial_bit_clock),
		.nrst(nrst),
		.clear(clr_link_r),
		.cs_n(cs_n),
		.word(result_sr_r),
		.data(link_data)
	);

	// The data pin picks the flop of the active clock source
	assign data_o = mode_ext ? link_data : int_data_r;

	// Enables follow select; the bit clock pin is an input in external mode
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			busy_oe_n <= 1'b1;
			data_oe_n <= 1'b1;
			bit_clk_oe_n <= 1'b1;
		end else if (clk_en) begin
			busy_oe_n <= pins_s.cs_n;
			data_oe_n <= pins_s.cs_n;
			bit_clk_oe_n <= pins_s.cs_n | mode_ext;
		end
	end
endmodule // sar_readout

//--- testbench/sar_readout_assertions.sv
// Timing checker for the converter sequencer and serial readout
`timescale 1ns/10ps
module sar_readout_assertions (
	input wire logic ref_clk, // Converter clock
	input wire logic nrst, // Async reset, active low
	input wire logic clk_en, // Clock enable of the design
	input wire logic cs_n, // Device select
	input wire logic clock_source_select, // Mode pin
	input wire logic hold_o, // Hold
	input wire logic busy_n_o, // Busy, active low
	input wire logic busy_oe_n, // Busy enable, active low
	input wire logic data_o, // Serial data
	input wire logic bit_clk_o // Internal bit clock
);
	default clocking cb @(posedge ref_clk); endclocking
	// A freeze stretches every timing, so checks spanning one are dropped
	default disable iff (!nrst || !clk_en);
	logic [4:0] rise_r;

	// Internal clock rises per busy frame, cleared as busy falls
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst)
			rise_r <= 5'h00;
		else if ($fell(busy_n_o))
			rise_r <= 5'h00;
		else if ($rose(bit_clk_o))
			rise_r <= rise_r + 5'h01;
	end

	a_busy_len: assert property ($fell(busy_n_o) |-> (!busy_n_o throughout ##151 1) ##1 busy_n_o)
		else $error("busy low length wrong");
	a_hold_len: assert property ($rose(hold_o) |-> (hold_o throughout ##140 1) ##1 !hold_o)
		else $error("hold length wrong");
	a_hold_busy: assert property ($rose(hold_o) |-> $fell(busy_n_o))
		else $error("hold and busy not together");
	a_busy_off: assert property (cs_n [*5] |-> busy_oe_n)
		else $error("busy driven while deselected");
	a_busy_on: assert property ((!cs_n) [*5] |-> !busy_oe_n)
		else $error("busy not driven while selected");
	a_idle_low: assert property ((!clock_source_select) [*5] ##0 busy_n_o |-> !data_o && !bit_clk_o)
		else $error("idle data or clock not low");
	a_frame_busy: assert property (bit_clk_o |-> !busy_n_o)
		else $error("bit clock outside busy");
	a_bit_stable: assert property ($rose(bit_clk_o) |-> $stable(data_o) [*6])
		else $error("data moved around clock edges");
	a_clk_high: assert property ($rose(bit_clk_o) |-> bit_clk_o [*4] ##1 !bit_clk_o)
		else $error("bit clock high time wrong");
	a_bit_count: assert property ($rose(busy_n_o) && !clock_source_select && !busy_oe_n |-> rise_r == 5'h0c)
		else $error("frame clock count wrong");
endmodule // sar_readout_assertions

//--- testbench/sar_host_model.sv
// Host serial reader: makes the external bit clock and samples data
`timescale 1ns/10ps
module sar_host_model (
	input wire logic data_o, // Device data
	input wire logic data_oe_n, // Data enable, active low
	input wire logic busy_n_o, // Device busy
	output logic serial_bit_clock // Host bit clock
);
	// A released pad shows the opposite level, never a kind stale value
	wire logic data_pad = data_o ^ data_oe_n;
	initial serial_bit_clock = 1'b0;

	// Clock runs only inside a read and idles low, so loads are kept
	task automatic xfer(input int n, input bit stall, output logic [15:0] w);
		w = '0;
		#33;
		for (int i = 0; i < n; i++) begin
			serial_bit_clock = 1'b1;
			if (stall && i == 0)
				wait (busy_n_o);
			#80;
			w = {w[14:0], data_pad};
			serial_bit_clock = 1'b0;
			#80;
		end
	endtask
endmodule // sar_host_model

//--- testbench/sar_readout_tb_top.sv
// Self-checking bench for the converter sequencer and serial readout
`timescale 1ns/10ps
module sar_readout_tb_top;
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic start_n = 1'b1;
	logic cs_n = 1'b0;
	logic mode = 1'b1;
	logic en = 1'b1;
	logic [11:0] code = 12'h000;
	wire logic sclk, hold_o, busy_n_o, busy_oe_n, data_o, data_oe_n, bit_clk_o, bit_clk_oe_n;
	int error_cnt = 0;
	int check_count = 0;

	sar_readout sar_readout_i (.ref_clk(ref_clk), .nrst(nrst), .clk_en(en), .convert_start_n(start_n),
		.cs_n(cs_n), .clock_source_select(mode), .serial_bit_clock(sclk), .sar_code(code), .hold_o(hold_o),
		.busy_n_o(busy_n_o), .busy_oe_n(busy_oe_n), .data_o(data_o), .data_oe_n(data_oe_n),
		.bit_clk_o(bit_clk_o), .bit_clk_oe_n(bit_clk_oe_n));
	sar_host_model sar_host_model_i (.data_o(data_o), .data_oe_n(data_oe_n), .busy_n_o(busy_n_o),
		.serial_bit_clock(sclk));

	always #50 ref_clk = ~ref_clk;

	task automatic finish_test;
		$display("checks %0d, errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input string name, input logic [11:0] got, input logic [11:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value %s: expected %h, seen %h", name, exp, got);
		end
	endtask

	// Inputs always move 10 ns after the clock edge
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#10;
	endtask

	task automatic rst;
		nrst = 1'b0;
		tick(6);
		nrst = 1'b1;
		tick(3);
	endtask

	// Start falls; a pulse is released after one cycle, else held until busy ends
	task automatic go(input logic [11:0] c, input bit pulse);
		tick(1);
		code = c;
		start_n = 1'b0;
		tick(1);
		if (pulse)
			start_n = 1'b1;
		for (int i = 0; i < 8 && busy_n_o !== 1'b0; i++)
			tick(1);
		chk("hold busy", {10'h000, hold_o, busy_n_o}, 12'h002);
	endtask

	// Gap after busy keeps start high long and the rate under the limit
	task automatic done;
		tick(1);
		for (int i = 0; i < 200 && busy_n_o !== 1'b1; i++)
			tick(1);
		chk("busy end", {11'h000, busy_n_o}, 12'h001);
		start_n = 1'b1;
		tick(100);
	endtask

	task automatic frame(output logic [11:0] w);
		w = '0;
		repeat (12) begin
			@(posedge bit_clk_o);
			#10;
			w = {w[10:0], data_o};
		end
	endtask

	task automatic s_ext;
		logic [11:0] t [4] = '{12'h000, 12'h7FF, 12'h800, 12'hFFF};
		logic [15:0] w;
		sar_host_model_i.xfer(2, 0, w);
		foreach (t[i]) begin
			go(t[i], i % 2);
			done();
			sar_host_model_i.xfer(14, 0, w);
			chk("ext word", w[13:2], t[i] ^ 12'h800);
			chk("ext tail", {10'h000, w[1:0]}, 12'h000);
		end
		chk("ext oe", {9'h000, busy_oe_n, data_oe_n, bit_clk_oe_n}, 12'h001);
	endtask

	task automatic s_during;
		logic [15:0] a;
		logic [15:0] b;
		// Fresh unread result, as the last one was read out in full
		go(12'hFFF, 0);
		done();
		go(12'h123, 0);
		sar_host_model_i.xfer(12, 0, a);
		chk("during", a[11:0], 12'h7FF);
		done();
		sar_host_model_i.xfer(6, 0, a);
		go(12'h456, 0);
		sar_host_model_i.xfer(6, 0, b);
		chk("split", {a[5:0], b[5:0]}, 12'h923);
		done();
		go(12'h789, 0);
		sar_host_model_i.xfer(12, 1, a);
		chk("refused", a[11:0], 12'hC56);
		done();
		sar_host_model_i.xfer(12, 0, a);
		chk("stale count", a[11:0], 12'h000);
	endtask

	task automatic s_int;
		logic [11:0] w;
		tick(1);
		mode = 1'b0;
		rst();
		go(12'h0F0, 0);
		done();
		go(12'hABC, 0);
		frame(w);
		chk("int frame", w, 12'h8F0);
		done();
		chk("int idle", {10'h000, data_o, bit_clk_o}, 12'h000);
		cs_n = 1'b1;
		tick(5);
		go(12'h321, 1);
		chk("oe off", {9'h000, busy_oe_n, data_oe_n, bit_clk_oe_n}, 12'h007);
		tick(40);
		start_n = 1'b0;
		tick(2);
		start_n = 1'b1;
		tick(109);
		chk("busy length", {11'h000, busy_n_o}, 12'h000);
		tick(1);
		chk("no restart", {11'h000, busy_n_o}, 12'h001);
		done();
		cs_n = 1'b0;
		tick(5);
		go(12'h555, 0);
		frame(w);
		chk("lost frame", w, 12'hB21);
		done();
		chk("oe on", {9'h000, busy_oe_n, data_oe_n, bit_clk_oe_n}, 12'h000);
	endtask

	// Enable low for 20 cycles must stretch busy by exactly 20 cycles
	task automatic s_freeze;
		go(12'h000, 0);
		en = 1'b0;
		tick(20);
		chk("frozen", {10'h000, hold_o, busy_n_o}, 12'h002);
		en = 1'b1;
		tick(151);
		chk("late busy", {11'h000, busy_n_o}, 12'h000);
		tick(1);
		chk("busy after", {11'h000, busy_n_o}, 12'h001);
		done();
	endtask

	initial begin
		rst();
		s_ext();
		s_during();
		s_int();
		s_freeze();
		finish_test();
	end

	// Whole run is near 3500 cycles; this bound catches a hang
	initial begin
		repeat (12000) @(posedge ref_clk);
		error_cnt++;
		finish_test();
	end
endmodule // sar_readout_tb_top

bind sar_readout sar_readout_assertions sar_readout_assertions_i (.ref_clk(ref_clk), .nrst(nrst), .clk_en(clk_en),
	.cs_n(cs_n),
	.clock_source_select(clock_source_select), .hold_o(hold_o), .busy_n_o(busy_n_o), .busy_oe_n(busy_oe_n),
	.data_o(data_o), .bit_clk_o(bit_clk_o));
